/* File: src/bcmc_pkg.sv */
package bcmc_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_IFAST    = 8'h04;
    localparam logic [7:0] OFF_TRIM     = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_SETPT    = 8'h18;

    // Field positions.
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_SRC_BIT   = 1;
    localparam int TRIM_LOAD_BIT  = 0;

    // Current setpoint limits and reset setpoint in mA, and the trim reset value.
    localparam logic [7:0] IFAST_MIN_MA = 8'h0a;
    localparam logic [7:0] IFAST_MAX_MA = 8'hc8;
    localparam logic [7:0] IFAST_RST_MA = 8'h64;
    localparam logic [7:0] TRIM_RST     = 8'h00;

    // Interrupt event bit positions.
    localparam int EV_MODE  = 0;
    localparam int EV_ERROR = 1;
    localparam int EV_STBY  = 2;
    localparam int EV_NUM   = 3;

    localparam logic [EV_NUM-1:0] IRQ_MASK_RST = 3'h0;

    typedef enum logic [2:0] {
        MODE_DISABLED = 3'b000,
        MODE_TRICKLE  = 3'b001,
        MODE_FAST     = 3'b010,
        MODE_STANDBY  = 3'b011,
        MODE_ERROR    = 3'b100
    } bcmc_mode_t;
endpackage

/* File: src/bcmc_sync.sv */
module bcmc_sync
    import bcmc_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1_q <= '0;
            syncOut  <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule

/* File: src/bcmc_current_calc.sv */
module bcmc_current_calc
    import bcmc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  bcmc_mode_t      mode,
    input  wire logic [7:0] fastMa,
    output logic      [7:0] currentMa,
    output logic            cvRegulate
);
    // Trickle current is about a tenth of the fast current.
    function automatic logic [7:0] tenth(input logic [7:0] v);
        tenth = 8'((16'(v) * 16'h001a) >> 8);
    endfunction

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            currentMa <= 8'h00;
        end else begin
            unique case (mode)
                MODE_TRICKLE: currentMa <= tenth(fastMa); // [R14]
                MODE_FAST:    currentMa <= fastMa;        // [R1]
                default:      currentMa <= 8'h00;         // [R7] [R13]
            endcase
        end
    end

    // Voltage regulation is only ever requested in fast charge; cvRegulate is combinational, and the top registers it with floatS before the analog loop.
    assign cvRegulate = (mode == MODE_FAST); // [R3]
endmodule

/* File: src/battery_charger_mode_control.sv */
// Functional notes
// R1 - Battery above fast threshold selects fast charge at programmed current.
// R2 - Fast current programmable 10 to 200 mA from stored key or supervisor.
// R3 - Fast charge holds constant current until float, then holds voltage.
// R4 - Current below termination level stops charge and enters standby.
// R5 - Standby returns to fast charge when battery drops below float minus hysteresis.
// R6 - Battery above input voltage minus margin enters error mode.
// R7 - Error mode sources no charge current.
// R8 - Error clears by itself when the input condition clears, no reset.
// R9 - Trim defaults come from nonvolatile storage values.
// R10 - Setup uses stored key settings and supervisor calls, applies initial trim.
// R11 - Supervisor enables or disables charger from temperature and time.
// R12 - Supervisor handles power events and drives status indicators.
// R13 - Not enabled means disabled mode and no current; disabled after reset.
// R14 - Enabled and below fast threshold selects trickle at a tenth current.
// R15 - Fast threshold detection has hysteresis to avoid oscillation.
// R16 - Inputs are synchronised; error has priority over other enabled modes.
// R17 - Current mode is shown as an encoded status output.
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
module battery_charger_mode_control
    import bcmc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        aboveFastHi,
    input  wire logic        aboveFastLo,
    input  wire logic        atFloat,
    input  wire logic        belowFloatHyst,
    input  wire logic        nearInputVoltage,
    input  wire logic        belowTermCurrent,
    input  wire logic [7:0]  storedConfigKeyIfast,
    input  wire logic [7:0]  nvTrimDefault,
    output logic      [2:0]  chargeMode,
    output logic      [7:0]  chargeCurrentMa,
    output logic             constantVoltage,
    output logic      [7:0]  analogTrim,
    output logic             irq
);
    logic [5:0] syncIn;
    logic [5:0] asyncBundle;
    logic       fastHiS;
    logic       fastLoS;
    logic       floatS;
    logic       hystS;
    logic       errS;
    logic       termS;

    // Comparator outputs are asynchronous to this clock. [R16]
    assign asyncBundle = {
        aboveFastHi,
        aboveFastLo,
        atFloat,
        belowFloatHyst,
        nearInputVoltage,
        belowTermCurrent
    };

    // Two flops per comparator trade two cycles of latency for metastability margin.
    bcmc_sync #(.WIDTH(6)) uSync (
        .clock   (clock),
        .rst     (rst),
        .asyncIn (asyncBundle),
        .syncOut (syncIn)
    );
    assign {fastHiS, fastLoS, floatS, hystS, errS, termS} = syncIn;

    // Bus address phase capture.
    logic        wrPend_q;
    logic [7:0]  addr_q;
    logic        take;

    assign take = hsel && hready && htrans[1];

    // Writes land in the data phase, where hwdata is valid.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPend_q <= 1'b0;
        end else begin
            wrPend_q <= take && hwrite;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_q <= 8'h00;
        end else if (take) begin
            addr_q <= haddr[7:0];
        end
    end

    // The slave never stalls, so back-to-back transfers see no wait states.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Configuration registers.
    logic             enable_q;
    logic             useSw_q;
    logic [7:0]       swIfast_q;
    logic [7:0]       trim_q;
    logic             trimLoaded_q;
    logic [EV_NUM-1:0] irqStat_q;
    logic [EV_NUM-1:0] irqMask_q;
    logic [7:0]       fastMa;
    logic [7:0]       keyMa_q;
    logic             wrCtrl;
    logic             wrIfast;
    logic             wrTrim;
    logic             wrClr;
    logic             wrMask;

    function automatic logic regHit(
        input logic       pend,
        input logic [7:0] a,
        input logic [7:0] off
    );
        regHit = pend && (a == off);
    endfunction

    assign wrCtrl  = regHit(wrPend_q, addr_q, OFF_CTRL);
    assign wrIfast = regHit(wrPend_q, addr_q, OFF_IFAST);
    assign wrTrim  = regHit(wrPend_q, addr_q, OFF_TRIM);
    assign wrClr   = regHit(wrPend_q, addr_q, OFF_IRQ_STAT);
    assign wrMask  = regHit(wrPend_q, addr_q, OFF_IRQ_MASK);

    function automatic logic [7:0] clampMa(input logic [7:0] v);
        if (v < IFAST_MIN_MA) begin
            clampMa = IFAST_MIN_MA;
        end else if (v > IFAST_MAX_MA) begin
            clampMa = IFAST_MAX_MA;
        end else begin
            clampMa = v;
        end
    endfunction

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0; // [R13]
        end else if (wrCtrl) begin
            enable_q <= hwdata[CTRL_EN_BIT]; // [R11]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            useSw_q <= 1'b0;
        end else if (wrCtrl) begin
            useSw_q <= hwdata[CTRL_SRC_BIT]; // [R10]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            swIfast_q <= IFAST_RST_MA;
        end else if (wrIfast) begin
            swIfast_q <= clampMa(hwdata[7:0]); // [R2]
        end
    end

    // Registering the clamped key keeps its comparators off the current path.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keyMa_q <= IFAST_MIN_MA;
        end else begin
            keyMa_q <= clampMa(storedConfigKeyIfast); // [R2] [R10]
        end
    end

    // The stored key applies unless supervisory code has taken over the setpoint.
    assign fastMa = useSw_q ? swIfast_q : keyMa_q; // [R2] [R10]

    // Trim loads the stored default once after reset; software may override later.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trimLoaded_q <= 1'b0;
        end else begin
            trimLoaded_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trim_q <= TRIM_RST;
        end else if (!trimLoaded_q) begin
            trim_q <= nvTrimDefault; // [R9] [R10]
        end else if (wrTrim) begin
            trim_q <= hwdata[7:0]; // [R10]
        end
    end
    assign analogTrim = trim_q;

    // Mode selection.
    bcmc_mode_t mode_q;
    bcmc_mode_t mode_d;
    logic       fastZone_q;

    // The fast zone uses two thresholds so noise near one cannot toggle modes.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fastZone_q <= 1'b0;
        end else if (fastHiS) begin
            fastZone_q <= 1'b1; // [R15]
        end else if (!fastLoS) begin
            fastZone_q <= 1'b0; // [R15]
        end
    end

    // Disabled wins over error, and error wins over every enabled mode.
    always_comb begin
        mode_d = mode_q;
        if (!enable_q) begin
            mode_d = MODE_DISABLED; // [R13]
        end else if (errS) begin
            mode_d = MODE_ERROR; // [R6] [R16]
        end else begin
            unique case (mode_q)
                MODE_DISABLED, MODE_ERROR: begin
                    // Leaving error needs no reset: selection just resumes. [R8]
                    mode_d = fastZone_q ? MODE_FAST : MODE_TRICKLE;
                end
                MODE_TRICKLE: begin
                    if (fastZone_q) begin
                        mode_d = MODE_FAST; // [R1]
                    end
                end
                MODE_FAST: begin
                    if (!fastZone_q) begin
                        mode_d = MODE_TRICKLE; // [R14]
                    end else if (floatS && termS) begin
                        mode_d = MODE_STANDBY; // [R4]
                    end
                end
                MODE_STANDBY: begin
                    // A cell that sagged below the fast band restarts in trickle.
                    if (hystS && fastZone_q) begin
                        mode_d = MODE_FAST; // [R5]
                    end else if (hystS) begin
                        mode_d = MODE_TRICKLE; // [R14]
                    end
                end
                default: mode_d = MODE_DISABLED;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_DISABLED; // [R13]
        end else begin
            mode_q <= mode_d;
        end
    end

    assign chargeMode = mode_q; // [R17]

    logic [7:0] curMa;
    logic       fastCv;

    bcmc_current_calc uCur (
        .clock      (clock),
        .rst        (rst),
        .mode       (mode_q),
        .fastMa     (fastMa),
        .currentMa  (curMa),
        .cvRegulate (fastCv)
    );
    assign chargeCurrentMa = curMa;

    // The analog loop holds voltage once float is reached in fast charge.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            constantVoltage <= 1'b0;
        end else begin
            constantVoltage <= fastCv && floatS; // [R3]
        end
    end

    // Interrupts: events set sticky bits; set wins over a write-one clear.
    logic [EV_NUM-1:0] events;
    logic [EV_NUM-1:0] clrBits;

    function automatic logic entering(
        input bcmc_mode_t nxt,
        input bcmc_mode_t cur,
        input bcmc_mode_t target
    );
        entering = (nxt == target) && (cur != target);
    endfunction

    assign events[EV_MODE]  = mode_d != mode_q;
    assign events[EV_ERROR] = entering(mode_d, mode_q, MODE_ERROR);
    assign events[EV_STBY]  = entering(mode_d, mode_q, MODE_STANDBY);
    assign clrBits          = wrClr ? hwdata[EV_NUM-1:0] : '0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= (irqStat_q & ~clrBits) | events;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqMask_q <= IRQ_MASK_RST;
        end else if (wrMask) begin
            irqMask_q <= hwdata[EV_NUM-1:0];
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    // Read data are registered at the end of the address phase, ready for the data phase.
    logic [31:0] rdMux;
    logic [7:0]  statusByte;

    assign statusByte = {constantVoltage, fastZone_q, 3'h0, mode_q};
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (haddr[7:0])
            OFF_CTRL:     rdMux = {30'h0, useSw_q, enable_q};
            OFF_IFAST:    rdMux = {24'h0, swIfast_q};
            OFF_TRIM:     rdMux = {24'h0, trim_q};
            OFF_STATUS:   rdMux = {24'h0, statusByte};
            OFF_IRQ_STAT: rdMux = {29'h0, irqStat_q};
            OFF_IRQ_MASK: rdMux = {29'h0, irqMask_q};
            OFF_SETPT:    rdMux = {16'h0, curMa, fastMa};
            default:      rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= rdMux;
        end
    end
endmodule

/* File: tb/bcmc_analog_model.sv */
module bcmc_analog_model #(
    parameter int FAST_HI_MV = 3000,
    parameter int FAST_LO_MV = 2900,
    parameter int FLOAT_MV   = 4200,
    parameter int HYST_MV    = 100,
    parameter int MARGIN_MV  = 50
) (
    input  var int     batMv,
    input  var int     chgMv,
    input  wire logic  taperDone,
    output logic       aboveFastHi,
    output logic       aboveFastLo,
    output logic       atFloat,
    output logic       belowFloatHyst,
    output logic       nearInputVoltage,
    output logic       belowTermCurrent
);
    timeunit 1ns;
    timeprecision 1ps;
    // Two thresholds give the fast-zone detector its hysteresis band.
    assign aboveFastHi      = batMv > FAST_HI_MV;
    assign aboveFastLo      = batMv > FAST_LO_MV;
    assign atFloat          = batMv >= FLOAT_MV;
    assign belowFloatHyst   = batMv < FLOAT_MV - HYST_MV;
    assign nearInputVoltage = batMv > chgMv - MARGIN_MV;
    // The taper only ends once the cell sits at float, as a real charger would.
    assign belowTermCurrent = taperDone && atFloat;
endmodule

/* File: tb/bcmc_checker_sva.sv */
module bcmc_checker
    import bcmc_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       aboveFastLo,
    input wire logic       nearInputVoltage,
    input wire logic [2:0] chargeMode,
    input wire logic [7:0] chargeCurrentMa,
    input wire logic       constantVoltage
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Four samples cover the two sync flops plus the mode register.
    sequence s_err_held;
        nearInputVoltage [*4];
    endsequence
    sequence s_err_clear;
        (!nearInputVoltage) [*4];
    endsequence
    a_mode_legal: assert property (chargeMode <= 3'h4)
        else $error("mode code out of range");
    a_dis_idle: assert property ((chargeMode == MODE_DISABLED) [*2] |-> chargeCurrentMa == 8'h00)
        else $error("current while disabled");
    a_err_idle: assert property ((chargeMode == MODE_ERROR) [*2] |-> chargeCurrentMa == 8'h00)
        else $error("current while in error");
    a_err_prio: assert property (s_err_held ##0 chargeMode != MODE_DISABLED |-> chargeMode == MODE_ERROR)
        else $error("error condition not taken");
    a_err_exit: assert property (s_err_clear |-> chargeMode != MODE_ERROR)
        else $error("error mode kept after input recovered");
    a_fast_hold: assert property (aboveFastLo [*4] ##0 chargeMode == MODE_FAST |=> chargeMode != MODE_TRICKLE)
        else $error("fast dropped inside hysteresis band");
    a_cv_fast: assert property (constantVoltage |-> chargeMode == MODE_FAST || $past(chargeMode) == MODE_FAST)
        else $error("constant voltage outside fast charge");
    a_stby_entry: assert property ($changed(chargeMode) && chargeMode == MODE_STANDBY |-> $past(chargeMode) == MODE_FAST)
        else $error("standby entered from wrong mode");
    a_trickle_cur: assert property ((chargeMode == MODE_TRICKLE) [*2] |-> chargeCurrentMa inside {[8'h01:8'h14]})
        else $error("trickle current out of range");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error response");
endmodule

bind battery_charger_mode_control bcmc_checker chk_u (
    .clock(clock), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .aboveFastLo(aboveFastLo),
    .nearInputVoltage(nearInputVoltage), .chargeMode(chargeMode),
    .chargeCurrentMa(chargeCurrentMa), .constantVoltage(constantVoltage)
);

/* File: tb/battery_charger_mode_control_tb.sv */
module battery_charger_mode_control_tb;
    import bcmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst, hsel, hwrite, hready, hreadyout, hresp, taperDone;
    logic        aFastHi, aFastLo, atFlt, bFltHyst, nearIn, bTerm, constantVoltage, irq;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize, chargeMode;
    logic [7:0]  storedConfigKeyIfast, nvTrimDefault, chargeCurrentMa, analogTrim;
    int          batMv, chgMv, num_errors, n_tests, cycles;
    assign hready = hreadyout;
    always #10 clock = ~clock;
    bcmc_analog_model pm_u (.batMv(batMv), .chgMv(chgMv), .taperDone(taperDone),
        .aboveFastHi(aFastHi), .aboveFastLo(aFastLo), .atFloat(atFlt),
        .belowFloatHyst(bFltHyst), .nearInputVoltage(nearIn), .belowTermCurrent(bTerm));
    battery_charger_mode_control dut_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .aboveFastHi(aFastHi),
        .aboveFastLo(aFastLo), .atFloat(atFlt), .belowFloatHyst(bFltHyst),
        .nearInputVoltage(nearIn), .belowTermCurrent(bTerm),
        .storedConfigKeyIfast(storedConfigKeyIfast), .nvTrimDefault(nvTrimDefault),
        .chargeMode(chargeMode), .chargeCurrentMa(chargeCurrentMa),
        .constantVoltage(constantVoltage), .analogTrim(analogTrim), .irq(irq));
    task tally_and_finish;
        $display("errors=%0d comparisons=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w; hsize <= 3'h2;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // Outputs are looked at mid-cycle, after the synchroniser and mode pipeline settle.
    task mchk(input logic [2:0] m, input logic [7:0] c);
        repeat (8) @(posedge clock);
        @(negedge clock);
        chk({29'h0, chargeMode}, {29'h0, m});
        chk({24'h0, chargeCurrentMa}, {24'h0, c});
        @(posedge clock);
    endtask
    task ichk(input logic v);
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk({31'h0, irq}, {31'h0, v});
        @(posedge clock);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        clock = 0; rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
        hwdata = 0; batMv = 2500; chgMv = 5000; taperDone = 0;
        storedConfigKeyIfast = 8'h05; nvTrimDefault = 8'h5a;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        mchk(MODE_DISABLED, 8'h00);
        chk({24'h0, analogTrim}, 32'h5a);
        rdc(OFF_IFAST, {24'h0, IFAST_RST_MA});
        rdc(OFF_IRQ_MASK, 32'h0);
        rdc(8'h1c, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h1);
        mchk(MODE_TRICKLE, 8'h01);
        rdc(OFF_SETPT, 32'h010a);
        bus(1'b1, OFF_IFAST, 32'hff);
        rdc(OFF_IFAST, 32'hc8);
        bus(1'b1, OFF_CTRL, 32'h3);
        rdc(OFF_CTRL, 32'h3);
        mchk(MODE_TRICKLE, 8'h14);
        bus(1'b1, OFF_IFAST, 32'h96);
        mchk(MODE_TRICKLE, 8'h0f);
        bus(1'b1, OFF_IRQ_MASK, 32'h7);
        bus(1'b1, OFF_IRQ_STAT, 32'h7);
        ichk(1'b0);
        batMv <= 3100;
        mchk(MODE_FAST, 8'h96);
        batMv <= 2950;
        mchk(MODE_FAST, 8'h96);
        batMv <= 4200;
        mchk(MODE_FAST, 8'h96);
        chk({31'h0, constantVoltage}, 32'h1);
        rdc(OFF_STATUS, 32'hc2);
        taperDone <= 1'b1;
        mchk(MODE_STANDBY, 8'h00);
        ichk(1'b1);
        rdc(OFF_IRQ_STAT, 32'h5);
        bus(1'b1, OFF_IRQ_STAT, 32'h7);
        ichk(1'b0);
        rdc(OFF_IRQ_STAT, 32'h0);
        batMv <= 4050;
        mchk(MODE_FAST, 8'h96);
        bus(1'b1, OFF_IRQ_MASK, 32'h2);
        bus(1'b1, OFF_IRQ_STAT, 32'h7);
        chgMv <= 4080;
        mchk(MODE_ERROR, 8'h00);
        ichk(1'b1);
        rdc(OFF_IRQ_STAT, 32'h3);
        bus(1'b1, OFF_IRQ_MASK, 32'h0);
        ichk(1'b0);
        bus(1'b1, OFF_IRQ_MASK, 32'h2);
        ichk(1'b1);
        bus(1'b1, OFF_IRQ_STAT, 32'h2);
        ichk(1'b0);
        chgMv <= 5000;
        mchk(MODE_FAST, 8'h96);
        bus(1'b1, OFF_CTRL, 32'h0);
        mchk(MODE_DISABLED, 8'h00);
        bus(1'b1, OFF_TRIM, 32'h33);
        repeat (2) @(posedge clock);
        chk({24'h0, analogTrim}, 32'h33);
        rdc(OFF_TRIM, 32'h33);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        mchk(MODE_DISABLED, 8'h00);
        chk({24'h0, analogTrim}, 32'h5a);
        rdc(OFF_CTRL, 32'h0);
        tally_and_finish();
    end
endmodule
